/* hdl/ctrl_out_consts.svh */
// Offsets, field positions, reset values and timing counts of the mux
`ifndef CTRL_OUT_CONSTS_SVH
`define CTRL_OUT_CONSTS_SVH

// *****
// Register indices and byte addresses
// *****
`define SEL_IDX 12'h035
`define PATH_EN_IDX 12'h003
`define CFG_IDX 12'h040
`define STAT_IDX 12'h041
`define SEL_ADDR (`SEL_IDX * 12'h004)
`define PATH_EN_ADDR (`PATH_EN_IDX * 12'h004)
`define CFG_ADDR (`CFG_IDX * 12'h004)
`define STAT_ADDR (`STAT_IDX * 12'h004)

// *****
// Field positions
// *****
`define PE_RX1 0
`define PE_RX2 1
`define PE_TX1 2
`define PE_TX2 3
`define CFG_EXT_CTRL 0
`define CFG_GMODE_LO 1
`define CFG_GMODE_HI 2
`define CFG_RSSI_LO 3
`define CFG_RSSI_HI 4
`define CFG_SPLIT 5
`define ST_RX_ON 8
`define ST_TX_ON 9

// *****
// Reset values
// *****
`define SEL_RST 8'h00
`define PATH_EN_RST 4'h0
`define CFG_RST 6'h00

// *****
// Select codes
// *****
`define SEL_RX_FLAGS 8'h03
`define SEL_RX2_INDEX 8'h04
`define SEL_RX2_AGC 8'h05
`define SEL_RX1_INDEX 8'h06
`define SEL_RX1_STATE 8'h07
`define SEL_FAST_BOTH 8'h08
`define SEL_PATH_RSSI 8'h09
`define SEL_OVERFLOW 8'h0a

// *****
// Timing
// *****
`define CLK_PERIOD_NS 5
`define GAIN_CHG_PULSE_NS 30
`define SYM_RDY_PULSE_NS 60
`define GAIN_CHG_CYC \
   ((`GAIN_CHG_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SYM_RDY_CYC \
   ((`SYM_RDY_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PEAK_WAIT_CYC_DEF 16

`endif

/* hdl/ctrl_out_pkg.sv */
// Types used by the status output mux
package ctrl_out_pkg;

   typedef enum logic [1:0] {
      GAIN_MANUAL = 2'h0,
      GAIN_SLOW = 2'h1,
      GAIN_FAST = 2'h2,
      GAIN_HYBRID = 2'h3
   } gain_mode_type;

   typedef enum logic [1:0] {
      RSSI_ON_RX_ENTRY = 2'h0,
      RSSI_ON_GAIN_LOCK = 2'h1,
      RSSI_ON_OTHER = 2'h2,
      RSSI_NEVER = 2'h3
   } rssi_mode_type;

endpackage

/* hdl/rx_gain_status_output_mux.sv */
// Receive gain status multiplexer onto eight control output pins
`timescale 1ns/100ps
`default_nettype none
`include "ctrl_out_consts.svh"

// How it works
// - Low-power flag follows condition in fast/manual
// - Limiter overload sticky until gain change
// - Large converter overload sticky, peak-wait cleared
// - Small converter overload behaves likewise
// - Select 0x03 maps both channels' four flags
// - Select 0x04 maps Rx2 index, overloads, lock
// - Gain lock high only in fast lock
// - Gain change gives one stretched pulse
// - Select 0x05 maps gain change and Rx2 flags
// - Energy lost follows condition, fast mode only
// - Stronger signal follows condition, fast mode only
// - Select 0x06 maps Rx1 flags and index
// - Select 0x07 maps Rx1 flags, state, lock
// - Slow mode state never sets top bit
// - Select 0x08 maps fast indications both channels
// - Receive-on needs enable, state, optional pin
// - Transmit-on needs enable, state, optional pin
// - Preamble ready holds until chosen restart
// - Rx-entry restart drops ready while recomputing
// - Lock restart only after fresh Rx entry
// - Symbol ready pulses per symbol update
// - Select 0x0A maps filter overflow flags
// - Undefined selects drive all eight pins low
module rx_gain_status_output_mux
   import ctrl_out_pkg::*;
#(
   parameter int PEAK_WAIT_CYC = `PEAK_WAIT_CYC_DEF,
   parameter int GAIN_CHG_CYC = `GAIN_CHG_CYC,
   parameter int SYM_RDY_CYC = `SYM_RDY_CYC
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Receive gain control status, index 0 is Rx1
   input wire logic [1:0] low_power_cond,
   input wire logic [1:0] limiter_overload_det,
   input wire logic [1:0] large_converter_det,
   input wire logic [1:0] small_converter_det,
   input wire logic [1:0] gain_change_evt,
   input wire logic [1:0] gain_locked,
   input wire logic [1:0] energy_lost_cond,
   input wire logic [1:0] stronger_signal_cond,
   input wire logic [6:0] rx1_gain_index,
   input wire logic [6:0] rx2_gain_index,
   input wire logic [6:0] rx1_limiter_index,
   input wire logic [6:0] rx2_limiter_index,
   input wire logic [2:0] rx1_gain_loop_state,
   // Signal strength measurement
   input wire logic [1:0] preamble_word_valid,
   input wire logic [1:0] symbol_update_evt,
   // Enable state machine state
   input wire logic enable_state_machine_in_rx,
   input wire logic enable_state_machine_in_tx,
   input wire logic enable_state_machine_in_fdd,
   input wire logic enable_state_machine_in_alert,
   // Pins from the baseband processor
   input wire logic enable_pin,
   input wire logic tx_rx_select_pin,
   // Filter overflow, bit 6 third interpolator down to bit 0 rx FIR
   input wire logic [6:0] overflow_cond,
   // Control output pins
   output logic [7:0] ctrl_out
);

   // *****
   // Parameter checks
   // *****
   generate
      if (PEAK_WAIT_CYC < 1 || PEAK_WAIT_CYC > 255) begin : g_bad_wait
         $error("PEAK_WAIT_CYC must lie in 1..255");
      end
      if (GAIN_CHG_CYC < 1 || GAIN_CHG_CYC > 255) begin : g_bad_chg
         $error("GAIN_CHG_CYC must lie in 1..255");
      end
      if (SYM_RDY_CYC < 1 || SYM_RDY_CYC > 255) begin : g_bad_sym
         $error("SYM_RDY_CYC must lie in 1..255");
      end
   endgenerate

   localparam logic [7:0] PEAK_WAIT_LD = 8'(PEAK_WAIT_CYC);
   localparam logic [7:0] GAIN_CHG_LD = 8'(GAIN_CHG_CYC);
   localparam logic [7:0] SYM_RDY_LD = 8'(SYM_RDY_CYC);

   function automatic logic addr_hit(input logic [11:0] a,
                                     input logic [11:0] ref_a);
      addr_hit = (a == ref_a);
   endfunction

   // *****
   // Register bus
   // *****
   logic [7:0] sel_r;
   logic [3:0] path_en_r;
   logic [5:0] cfg_r;
   logic pready_r;
   logic pslverr_r;
   logic [31:0] prdata_r;
   logic [7:0] ctrl_out_r;
   logic rx_on_r;
   logic tx_on_r;

   wire setup_ph = psel & ~penable;
   wire wr_take = psel & penable & pready_r & pwrite;
   wire hit_sel = addr_hit(paddr, `SEL_ADDR);
   wire hit_pe = addr_hit(paddr, `PATH_EN_ADDR);
   wire hit_cfg = addr_hit(paddr, `CFG_ADDR);
   wire hit_stat = addr_hit(paddr, `STAT_ADDR);
   wire hit_any = hit_sel | hit_pe | hit_cfg | hit_stat;
   wire bad_acc = ~hit_any | (hit_stat & pwrite);
   wire [31:0] stat_word = {22'h0, tx_on_r, rx_on_r, ctrl_out_r};
   wire [31:0] rd_word =
      hit_sel ? {24'h0, sel_r} :
      hit_pe ? {28'h0, path_en_r} :
      hit_cfg ? {26'h0, cfg_r} :
      hit_stat ? stat_word : 32'h0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0;
      end else begin
         pready_r <= setup_ph;
         if (setup_ph) begin
            pslverr_r <= bad_acc;
            prdata_r <= pwrite ? 32'h0 : rd_word;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_r <= `SEL_RST;
         path_en_r <= `PATH_EN_RST;
         cfg_r <= `CFG_RST;
      end else if (wr_take) begin
         if (hit_sel) sel_r <= pwdata[7:0];
         if (hit_pe) path_en_r <= pwdata[3:0];
         if (hit_cfg) cfg_r <= pwdata[5:0];
      end
   end

   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign prdata = prdata_r;

   wire ext_ctrl = cfg_r[`CFG_EXT_CTRL];
   wire split_table = cfg_r[`CFG_SPLIT];
   gain_mode_type gain_mode;
   rssi_mode_type rssi_mode;
   assign gain_mode = gain_mode_type'(cfg_r[`CFG_GMODE_HI:`CFG_GMODE_LO]);
   assign rssi_mode = rssi_mode_type'(cfg_r[`CFG_RSSI_HI:`CFG_RSSI_LO]);
   wire fast_mode = (gain_mode == GAIN_FAST);
   wire slow_mode = (gain_mode == GAIN_SLOW);
   wire lowp_mode = fast_mode | (gain_mode == GAIN_MANUAL);

   // *****
   // Pin synchronisers
   // *****
   logic [1:0] pin_meta_r;
   logic [1:0] pin_sync_r;
   wire [1:0] pin_raw = {tx_rx_select_pin, enable_pin};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_meta_r <= 2'h0;
         pin_sync_r <= 2'h0;
      end else begin
         pin_meta_r <= pin_raw;
         pin_sync_r <= pin_meta_r;
      end
   end

   wire enable_sync = pin_sync_r[0];
   wire txrx_sync = pin_sync_r[1];

   // *****
   // Path on indications
   // *****
   wire rx_any_en = path_en_r[`PE_RX1] | path_en_r[`PE_RX2];
   wire tx_any_en = path_en_r[`PE_TX1] | path_en_r[`PE_TX2];
   wire rx_fdd_ok = enable_state_machine_in_fdd & (~ext_ctrl | enable_sync);
   wire tx_fdd_ok = enable_state_machine_in_fdd & (~ext_ctrl | txrx_sync);
   wire rx_on_nxt = rx_any_en & (enable_state_machine_in_rx | rx_fdd_ok);
   wire tx_on_nxt = tx_any_en & (enable_state_machine_in_tx | tx_fdd_ok);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_on_r <= 1'b0;
         tx_on_r <= 1'b0;
      end else begin
         rx_on_r <= rx_on_nxt;
         tx_on_r <= tx_on_nxt;
      end
   end

   // *****
   // Receive state entry tracking
   // *****
   logic rx_like_r;
   logic alert_seen_r;
   wire rx_like = enable_state_machine_in_rx | enable_state_machine_in_fdd;
   wire rx_entry = rx_like & ~rx_like_r;
   wire rx_entry_from_alert = rx_entry & alert_seen_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_like_r <= 1'b0;
         alert_seen_r <= 1'b0;
      end else begin
         rx_like_r <= rx_like;
         alert_seen_r <= enable_state_machine_in_alert;
      end
   end

   // *****
   // Per-channel status
   // *****
   logic [1:0] lim_ovl_r;
   logic [1:0] lg_conv_r;
   logic [1:0] sm_conv_r;
   logic [1:0] gain_chg_r;
   logic [1:0] pre_rdy_r;
   logic [1:0] sym_rdy_r;
   logic [1:0] lock_d_r;

   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++) begin : g_ch
         logic [7:0] wait_cnt_r;
         logic [7:0] chg_cnt_r;
         logic [7:0] sym_cnt_r;
         logic lock_armed_r;
         wire det_hold = (wait_cnt_r != 8'h00) | gain_change_evt[ch];
         wire lock_rise = gain_locked[ch] & ~lock_d_r[ch];
         wire restart_rx = (rssi_mode == RSSI_ON_RX_ENTRY) &
                           rx_entry_from_alert;
         wire restart_lock = (rssi_mode == RSSI_ON_GAIN_LOCK) &
                             fast_mode & lock_rise & lock_armed_r;
         wire pre_restart = restart_rx | restart_lock;

         // Detectors sit in reset from a gain change until wait expiry
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               wait_cnt_r <= 8'h00;
            end else if (gain_change_evt[ch]) begin
               wait_cnt_r <= PEAK_WAIT_LD;
            end else if (wait_cnt_r != 8'h00) begin
               wait_cnt_r <= wait_cnt_r - 8'h01;
            end
         end

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               lim_ovl_r[ch] <= 1'b0;
               lg_conv_r[ch] <= 1'b0;
               sm_conv_r[ch] <= 1'b0;
            end else if (det_hold) begin
               lim_ovl_r[ch] <= 1'b0;
               lg_conv_r[ch] <= 1'b0;
               sm_conv_r[ch] <= 1'b0;
            end else begin
               lim_ovl_r[ch] <= lim_ovl_r[ch] | limiter_overload_det[ch];
               lg_conv_r[ch] <= lg_conv_r[ch] | large_converter_det[ch];
               sm_conv_r[ch] <= sm_conv_r[ch] | small_converter_det[ch];
            end
         end

         // Gain change pulse stretched to its documented width
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               chg_cnt_r <= 8'h00;
               gain_chg_r[ch] <= 1'b0;
            end else begin
               if (gain_change_evt[ch] && chg_cnt_r == 8'h00) begin
                  chg_cnt_r <= GAIN_CHG_LD;
               end else if (chg_cnt_r != 8'h00) begin
                  chg_cnt_r <= chg_cnt_r - 8'h01;
               end
               gain_chg_r[ch] <= (gain_change_evt[ch] &&
                                  chg_cnt_r == 8'h00) ||
                                 chg_cnt_r > 8'h01;
            end
         end

         // Symbol ready pulse
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               sym_cnt_r <= 8'h00;
               sym_rdy_r[ch] <= 1'b0;
            end else begin
               if (symbol_update_evt[ch]) begin
                  sym_cnt_r <= SYM_RDY_LD;
               end else if (sym_cnt_r != 8'h00) begin
                  sym_cnt_r <= sym_cnt_r - 8'h01;
               end
               sym_rdy_r[ch] <= symbol_update_evt[ch] |
                                (sym_cnt_r > 8'h01);
            end
         end

         // Lock restart is armed only by a fresh entry into receive
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               lock_armed_r <= 1'b0;
               lock_d_r[ch] <= 1'b0;
            end else begin
               lock_d_r[ch] <= gain_locked[ch];
               if (rx_entry) begin
                  lock_armed_r <= 1'b1;
               end else if (lock_rise || !rx_like) begin
                  lock_armed_r <= 1'b0;
               end
            end
         end

         // Preamble ready holds across alert and transmit states
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               pre_rdy_r[ch] <= 1'b0;
            end else if (pre_restart) begin
               pre_rdy_r[ch] <= 1'b0;
            end else if (preamble_word_valid[ch]) begin
               pre_rdy_r[ch] <= 1'b1;
            end
         end
      end
   endgenerate

   // *****
   // Qualified indications
   // *****
   wire [1:0] low_pow = low_power_cond & {2{lowp_mode}};
   wire [1:0] lock_q = gain_locked & {2{fast_mode}};
   wire [1:0] lost_q = energy_lost_cond & {2{fast_mode}};
   wire [1:0] strong_q = stronger_signal_cond & {2{fast_mode}};
   wire [2:0] state_q = {rx1_gain_loop_state[2] & ~slow_mode,
                         rx1_gain_loop_state[1:0]};
   wire [6:0] rx2_idx = split_table ? rx2_limiter_index : rx2_gain_index;
   wire [6:0] rx1_idx = split_table ? rx1_limiter_index : rx1_gain_index;

   // *****
   // Output groups
   // *****
   wire [7:0] grp_flags = {low_pow[0], lim_ovl_r[0], lg_conv_r[0],
                           sm_conv_r[0], low_pow[1], lim_ovl_r[1],
                           lg_conv_r[1], sm_conv_r[1]};
   wire [7:0] grp_rx2_idx = {rx2_idx[6:2], lim_ovl_r[1], lg_conv_r[1],
                             lock_q[1]};
   wire [7:0] grp_rx2_agc = {gain_chg_r[1], gain_chg_r[0], low_pow[1],
                             lim_ovl_r[1], lg_conv_r[1], lock_q[1],
                             lost_q[1], strong_q[1]};
   wire [7:0] grp_rx1_idx = {low_pow[0], lim_ovl_r[0], lg_conv_r[0],
                             rx1_idx[6:2]};
   wire [7:0] grp_rx1_st = {low_pow[0], lim_ovl_r[0], lg_conv_r[0],
                            sm_conv_r[0], state_q, lock_q[0]};
   wire [7:0] grp_fast = {strong_q[0], lock_q[0], lost_q[0],
                          gain_chg_r[0], strong_q[1], lock_q[1],
                          lost_q[1], gain_chg_r[1]};
   wire [7:0] grp_path = {rx_on_r, pre_rdy_r[0], sym_rdy_r[0], tx_on_r,
                          pre_rdy_r[1], sym_rdy_r[1], 2'b00};
   wire [7:0] grp_ovf = {overflow_cond, 1'b0};

   wire [7:0] ctrl_out_nxt =
      (sel_r == `SEL_RX_FLAGS) ? grp_flags :
      (sel_r == `SEL_RX2_INDEX) ? grp_rx2_idx :
      (sel_r == `SEL_RX2_AGC) ? grp_rx2_agc :
      (sel_r == `SEL_RX1_INDEX) ? grp_rx1_idx :
      (sel_r == `SEL_RX1_STATE) ? grp_rx1_st :
      (sel_r == `SEL_FAST_BOTH) ? grp_fast :
      (sel_r == `SEL_PATH_RSSI) ? grp_path :
      (sel_r == `SEL_OVERFLOW) ? grp_ovf :
      8'h00;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_out_r <= 8'h00;
      end else begin
         ctrl_out_r <= ctrl_out_nxt;
      end
   end

   assign ctrl_out = ctrl_out_r;

endmodule // rx_gain_status_output_mux

`default_nettype wire

/* dv/ctrl_out_sva.sv */
// Checker for the status output mux pins
`timescale 1ns/100ps
`default_nettype none
`include "ctrl_out_consts.svh"
module ctrl_out_sva (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Register bus
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic pready,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   // Sources
   input wire logic [1:0] gain_change_evt,
   input wire logic [1:0] symbol_update_evt,
   input wire logic [1:0] gain_locked,
   input wire logic [6:0] rx1_gain_index,
   input wire logic [6:0] rx2_gain_index,
   input wire logic [2:0] rx1_gain_loop_state,
   input wire logic [6:0] overflow_cond,
   // Pins
   input wire logic [7:0] ctrl_out
);
   // *****
   // Register shadow and settle count
   // *****
   logic [7:0] sel_r;
   logic [5:0] cfg_r;
   logic [3:0] quiet_r;
   logic [25:0] src_r;
   wire wr = psel && penable && pready && pwrite;
   wire [25:0] src = {overflow_cond, rx1_gain_index, rx2_gain_index,
      rx1_gain_loop_state, gain_locked};
   wire quiet = quiet_r[3];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_r <= 8'h00;
         cfg_r <= 6'h00;
         quiet_r <= 4'h0;
         src_r <= 26'h0;
      end else begin
         src_r <= src;
         if (wr && paddr == `SEL_ADDR) sel_r <= pwdata[7:0];
         if (wr && paddr == `CFG_ADDR) cfg_r <= pwdata[5:0];
         if (wr || src != src_r) quiet_r <= 4'h0;
         else if (!quiet) quiet_r <= quiet_r + 4'h1;
      end
   end
   // *****
   // Assertions
   // *****
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_gain_high;
      ctrl_out[6] [*6] ##1 !ctrl_out[6];
   endsequence
   sequence s_sym_high;
      ctrl_out[2] [*6] ##1 ctrl_out[2] [*6] ##1 !ctrl_out[2];
   endsequence
   a_ovf_map: assert property (
      quiet && sel_r == 8'h0a |-> ctrl_out == {overflow_cond, 1'b0})
      else $error("overflow pins wrong");
   a_rx2_index: assert property (
      quiet && sel_r == 8'h04 && !cfg_r[5]
      |-> ctrl_out[7:3] == rx2_gain_index[6:2]) else $error("rx2 index");
   a_rx1_index: assert property (
      quiet && sel_r == 8'h06 && !cfg_r[5]
      |-> ctrl_out[4:0] == rx1_gain_index[6:2]) else $error("rx1 index");
   a_slow_msb: assert property (
      quiet && sel_r == 8'h07 && cfg_r[2:1] == 2'h1 |-> !ctrl_out[3])
      else $error("slow state top bit set");
   a_lock_gated: assert property (
      quiet && sel_r == 8'h08 && cfg_r[2:1] != 2'h2
      |-> !ctrl_out[6] && !ctrl_out[2]) else $error("lock outside fast");
   a_gain_pulse: assert property (
      quiet && sel_r == 8'h05 && gain_change_evt[0] |-> ##2 s_gain_high)
      else $error("gain change pulse width");
   a_sym_pulse: assert property (
      quiet && sel_r == 8'h09 && symbol_update_evt[1] |-> ##2 s_sym_high)
      else $error("symbol ready pulse width");
   a_flags_clear: assert property (
      quiet && sel_r == 8'h03 && gain_change_evt[0]
      |-> ##2 (ctrl_out[6:4] == 3'h0) [*2]) else $error("flags not cleared");
   a_flag_sticky: assert property (
      quiet && sel_r == 8'h03 && ctrl_out[6] && !gain_change_evt[0]
      && !$past(gain_change_evt[0]) |=> ctrl_out[6]) else $error("flag fell");
endmodule // ctrl_out_sva
bind rx_gain_status_output_mux ctrl_out_sva chk (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .pready(pready), .paddr(paddr), .pwdata(pwdata),
   .gain_change_evt(gain_change_evt), .symbol_update_evt(symbol_update_evt),
   .gain_locked(gain_locked), .rx1_gain_index(rx1_gain_index),
   .rx2_gain_index(rx2_gain_index),
   .rx1_gain_loop_state(rx1_gain_loop_state),
   .overflow_cond(overflow_cond), .ctrl_out(ctrl_out));
`default_nettype wire

/* dv/bbp_model.sv */
// Baseband processor model: drives its pins, times pulses on one output
`timescale 1ns/100ps
`default_nettype none
module bbp_model (
   // Clock
   input wire logic pclk,
   // Requests from the bench
   input wire logic want_rx,
   input wire logic want_tx,
   input wire logic [2:0] watch_bit,
   // Device pins
   input wire logic [7:0] ctrl_out,
   output logic enable_pin,
   output logic tx_rx_select_pin,
   // Width in cycles of the last high pulse seen
   output logic [7:0] pulse_w
);
   logic [7:0] run_r;
   initial begin
      enable_pin = 1'b0;
      tx_rx_select_pin = 1'b0;
      pulse_w = 8'h00;
      run_r = 8'h00;
   end
   always @(posedge pclk) begin
      enable_pin <= want_rx;
      tx_rx_select_pin <= want_tx;
      if (ctrl_out[watch_bit]) run_r <= run_r + 8'h01;
      else if (run_r != 8'h00) begin
         pulse_w <= run_r;
         run_r <= 8'h00;
      end
   end
endmodule // bbp_model
`default_nettype wire

/* dv/testbench.sv */
// Self-checking bench for the status output mux
`timescale 1ns/100ps
`default_nettype none
`include "ctrl_out_consts.svh"
module testbench;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, enable_pin, tx_rx_select_pin;
   logic [7:0] ctrl_out, pulse_w;
   logic [1:0] low_power_cond = 2'h0, limiter_overload_det = 2'h0;
   logic [1:0] large_converter_det = 2'h0, small_converter_det = 2'h0;
   logic [1:0] gain_change_evt = 2'h0, gain_locked = 2'h0;
   logic [1:0] energy_lost_cond = 2'h0, stronger_signal_cond = 2'h0;
   logic [1:0] preamble_word_valid = 2'h0, symbol_update_evt = 2'h0;
   logic [6:0] rx1_gain_index = 7'h0, rx2_gain_index = 7'h0;
   logic [6:0] rx1_limiter_index = 7'h0, rx2_limiter_index = 7'h0;
   logic [6:0] overflow_cond = 7'h0;
   logic [2:0] rx1_gain_loop_state = 3'h0, watch_bit = 3'h0;
   logic enable_state_machine_in_rx = 1'b0, enable_state_machine_in_tx = 1'b0, enable_state_machine_in_fdd = 1'b0;
   logic enable_state_machine_in_alert = 1'b0, want_rx = 1'b0, want_tx = 1'b0;
   int err_count = 0, cmp_count = 0, i;
   rx_gain_status_output_mux #(.PEAK_WAIT_CYC(4)) dut (.pclk, .presetn,
      .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .low_power_cond, .limiter_overload_det,
      .large_converter_det, .small_converter_det, .gain_change_evt,
      .gain_locked, .energy_lost_cond, .stronger_signal_cond,
      .rx1_gain_index, .rx2_gain_index, .rx1_limiter_index,
      .rx2_limiter_index, .rx1_gain_loop_state, .preamble_word_valid,
      .symbol_update_evt, .enable_state_machine_in_rx, .enable_state_machine_in_tx, .enable_state_machine_in_fdd,
      .enable_state_machine_in_alert, .enable_pin, .tx_rx_select_pin, .overflow_cond,
      .ctrl_out);
   bbp_model bbp (.pclk, .want_rx, .want_tx, .watch_bit, .ctrl_out,
      .enable_pin, .tx_rx_select_pin, .pulse_w);
   // *****
   // Tasks
   // *****
   task automatic w(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic chk(input string n, input logic [31:0] e,
      input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         err_count++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic apb(input logic wr_en, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr_en;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] x,
      input logic xe);
      logic [31:0] q;
      logic e;
      apb(1'b0, a, 32'h0, q, e);
      chk("prdata", x, q);
      chk("pslverr", {31'h0, xe}, {31'h0, e});
   endtask
   task automatic pin(input logic [7:0] e);
      w(6);
      chk("ctrl_out", {24'h0, e}, {24'h0, ctrl_out});
   endtask
   task automatic complete_run;
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // *****
   // Clock, watchdog and tests
   // *****
   initial begin
      forever #2.5 pclk = ~pclk;
   end
   initial begin
      w(20000);
      err_count++;
      $display("watchdog expired");
      complete_run();
   end
   initial begin
      w(10);
      presetn <= 1'b1;
      rd(`SEL_ADDR, 32'h0, 1'b0);
      rd(`CFG_ADDR, 32'h0, 1'b0);
      rd(`PATH_EN_ADDR, 32'h0, 1'b0);
      wr(`SEL_ADDR, 32'hffff_ff3c);
      rd(`SEL_ADDR, 32'h3c, 1'b0);
      rd(12'hffc, 32'h0, 1'b1);
      $display("registers done");
      wr(`SEL_ADDR, 32'h0a);
      for (i = 0; i < 7; i++) begin
         overflow_cond <= 7'h01 << i;
         pin({7'h01 << i, 1'b0});
      end
      overflow_cond <= 7'h00;
      pin(8'h00);
      $display("overflow done");
      wr(`CFG_ADDR, 32'h4);
      wr(`SEL_ADDR, 32'h03);
      {low_power_cond, limiter_overload_det} <= 4'hf;
      {large_converter_det, small_converter_det} <= 4'hf;
      pin(8'hff);
      {limiter_overload_det, large_converter_det} <= 4'h0;
      small_converter_det <= 2'h0;
      pin(8'hff);
      {limiter_overload_det, large_converter_det} <= 4'hf;
      small_converter_det <= 2'h3;
      w(4);
      gain_change_evt <= 2'h3;
      w(1);
      gain_change_evt <= 2'h0;
      w(2);
      chk("flags", 32'h88, {24'h0, ctrl_out});
      pin(8'hff);
      wr(`CFG_ADDR, 32'h2);
      pin(8'h77);
      $display("flags done");
      wr(`CFG_ADDR, 32'h4);
      wr(`SEL_ADDR, 32'h04);
      gain_locked <= 2'h3;
      rx2_gain_index <= 7'h55;
      rx2_limiter_index <= 7'h2a;
      pin(8'haf);
      wr(`CFG_ADDR, 32'h24);
      pin(8'h57);
      wr(`CFG_ADDR, 32'h4);
      wr(`SEL_ADDR, 32'h06);
      rx1_gain_index <= 7'h4c;
      pin(8'hf3);
      wr(`SEL_ADDR, 32'h07);
      rx1_gain_loop_state <= 3'h5;
      pin(8'hfb);
      wr(`CFG_ADDR, 32'h2);
      pin(8'h72);
      $display("index and state done");
      wr(`CFG_ADDR, 32'h4);
      wr(`SEL_ADDR, 32'h05);
      {energy_lost_cond, stronger_signal_cond} <= 4'ha;
      pin(8'h3f);
      energy_lost_cond <= 2'h0;
      pin(8'h3d);
      for (i = 0; i < 2; i++) begin
         watch_bit <= 3'(6 + i);
         gain_change_evt <= 2'(1 << i);
         w(1);
         gain_change_evt <= 2'h0;
         w(14);
         chk("gain pulse", 32'h6, {24'h0, pulse_w});
      end
      wr(`SEL_ADDR, 32'h08);
      {energy_lost_cond, stronger_signal_cond} <= 4'hf;
      pin(8'hee);
      wr(`CFG_ADDR, 32'h0);
      pin(8'h00);
      $display("fast flags done");
      wr(`SEL_ADDR, 32'h09);
      wr(`PATH_EN_ADDR, 32'h5);
      enable_state_machine_in_rx <= 1'b1;
      pin(8'h80);
      {enable_state_machine_in_rx, enable_state_machine_in_tx} <= 2'h1;
      pin(8'h10);
      wr(`PATH_EN_ADDR, 32'h0);
      pin(8'h00);
      wr(`PATH_EN_ADDR, 32'h5);
      wr(`CFG_ADDR, 32'h1);
      {enable_state_machine_in_tx, enable_state_machine_in_fdd} <= 2'h1;
      pin(8'h00);
      {want_rx, want_tx} <= 2'h3;
      pin(8'h90);
      preamble_word_valid <= 2'h1;
      w(1);
      preamble_word_valid <= 2'h0;
      pin(8'hd0);
      {enable_state_machine_in_fdd, enable_state_machine_in_alert} <= 2'h1;
      pin(8'h40);
      {enable_state_machine_in_fdd, enable_state_machine_in_alert} <= 2'h2;
      pin(8'h90);
      preamble_word_valid <= 2'h1;
      w(1);
      preamble_word_valid <= 2'h0;
      pin(8'hd0);
      for (i = 0; i < 2; i++) begin
         watch_bit <= 3'(5 - 3 * i);
         symbol_update_evt <= 2'(1 << i);
         w(1);
         symbol_update_evt <= 2'h0;
         w(20);
         chk("symbol pulse", 32'hc, {24'h0, pulse_w});
      end
      gain_locked <= 2'h0;
      wr(`CFG_ADDR, 32'hd);
      w(4);
      gain_locked <= 2'h3;
      pin(8'h90);
      preamble_word_valid <= 2'h1;
      w(1);
      {preamble_word_valid, gain_locked} <= 4'h0;
      w(2);
      gain_locked <= 2'h3;
      pin(8'hd0);
      {enable_state_machine_in_fdd, enable_state_machine_in_alert} <= 2'h1;
      w(4);
      {enable_state_machine_in_fdd, enable_state_machine_in_alert} <= 2'h2;
      gain_locked <= 2'h0;
      pin(8'hd0);
      gain_locked <= 2'h3;
      pin(8'h90);
      $display("path and strength done");
      complete_run();
   end
endmodule // testbench
`default_nettype wire
